// File: design/wdt_defines.svh
// Register address, field positions, reset values and counts of the watchdog.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_CTRL_ADDR 8'hC0
`define WDT_CTRL_RESET 8'h10
`define WDT_BIT_PRE_LSB 4
`define WDT_BIT_IRQ_SEL 3
`define WDT_BIT_STATUS 2
`define WDT_BIT_ENABLE 1
`define WDT_BIT_UNLOCK 0
`define WDT_CNT_WIDTH 16
`define WDT_RC_BASE_PERIODS 17'h00200
`define WDT_RC_FREQ_HZ 32000
`define WDT_PRE_LAST_TIMED 4'h7
`define WDT_PRE_IMMEDIATE 4'h8

`endif

// File: design/wdt_pkg.sv
// Types shared by the watchdog timer unit.
`include "wdt_defines.svh"

package wdt_pkg;

    typedef struct packed {
        logic [3:0] timeout_select_field;
        logic irq_response_select;
        logic timeout_status_flag;
        logic watchdog_enable_bit;
        logic write_unlock_bit;
    } wdt_ctrl_type;

    typedef struct packed {
        logic byte_wr;
        logic bit_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_val;
    } wdt_sfr_req_type;

    typedef struct packed {
        wdt_ctrl_type ctrl;
        logic [`WDT_CNT_WIDTH-1:0] count;
        logic [2:0] rc_sync;
        logic [7:0] rdata;
        logic irq_req;
        logic sys_reset;
    } wdt_state_type;

endpackage

// File: design/wdt_unit.sv
// Watchdog timer unit with its write-protected control register.
`timescale 1ns/1ns
`include "wdt_defines.svh"

// What this block does
// - Disabled watchdog does nothing at all.
// - Missed refresh raises reset or interrupt.
// - Sixteen-bit counter on 32 kHz oscillator.
// - Control writes ignored unless first unlocked.
// - Timeout is 512 times two to code.
// - Response bit turns reset into interrupt, except for the immediate code.
// - Interrupt is fixed priority, never masked.
// - Interrupt mode works as periodic timer.
// - Every timeout sets the status flag.
// - Status cleared by zero write, hardware reset.
// - Writing enable one restarts the interval.
// - Enable cleared by zero, resets, supply alarm.
module wdt_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Free-running oscillator pin
    input wire logic rc_osc_clk,
    // Special function register access from the core
    input wire wdt_pkg::wdt_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    // Interrupt and reset requests
    input wire logic irq_ack,
    input wire logic supply_monitor_irq,
    output logic wd_irq_req,
    output logic wd_system_reset,
    output logic timeout_status_flag
);

    wdt_pkg::wdt_state_type state;
    wdt_pkg::wdt_state_type next_state;

    function automatic logic [`WDT_CNT_WIDTH-1:0] wdt_terminal(
        input logic [3:0] code
    );
        logic [16:0] span;
        span = `WDT_RC_BASE_PERIODS << code[2:0];
        return span[`WDT_CNT_WIDTH-1:0] - 16'h0001;
    endfunction

    function automatic logic [7:0] wdt_pack(
        input wdt_pkg::wdt_ctrl_type c
    );
        return {c.timeout_select_field, c.irq_response_select,
            c.timeout_status_flag, c.watchdog_enable_bit,
            c.write_unlock_bit};
    endfunction

    function automatic wdt_pkg::wdt_ctrl_type wdt_reset_ctrl(
        input logic keep_status
    );
        wdt_pkg::wdt_ctrl_type c;
        c = `WDT_CTRL_RESET;
        c.timeout_status_flag = keep_status;
        return c;
    endfunction

    logic ctrl_hit;
    logic set_unlock;
    logic any_write;
    logic write_ok;
    logic [7:0] mask;
    logic [7:0] data;
    logic rc_tick;
    logic timed_code;
    logic expire;
    logic restart;

    always_comb begin
        next_state = state;
        // The first stage only feeds the second to settle metastability.
        next_state.rc_sync = {state.rc_sync[1:0], rc_osc_clk};
        rc_tick = state.rc_sync[1] & ~state.rc_sync[2];
        ctrl_hit = 1'b0;
        mask = 8'h00;
        data = 8'h00;
        if (sfr_req.byte_wr && sfr_req.addr == `WDT_CTRL_ADDR) begin
            ctrl_hit = 1'b1;
            mask = 8'hFF;
            data = sfr_req.wdata;
        end
        // Bit addresses of the control byte share its upper five bits.
        if (sfr_req.bit_wr
            && sfr_req.addr[7:3] == 5'(`WDT_CTRL_ADDR >> 3)) begin
            ctrl_hit = 1'b1;
            mask = 8'h01 << sfr_req.addr[2:0];
            data = {8{sfr_req.bit_val}};
        end
        // Only a bit set of the unlock bit opens the register.
        set_unlock = sfr_req.bit_wr && sfr_req.bit_val
            && sfr_req.addr == (`WDT_CTRL_ADDR | 8'h00);
        any_write = sfr_req.byte_wr || sfr_req.bit_wr;
        write_ok = ctrl_hit && !set_unlock
            && state.ctrl.write_unlock_bit;
        restart = 1'b0;
        if (set_unlock) begin
            next_state.ctrl.write_unlock_bit = 1'b1;
        end else if (any_write) begin
            next_state.ctrl.write_unlock_bit = 1'b0;
        end
        if (write_ok) begin
            for (int i = 0; i < 4; i++) begin
                if (mask[`WDT_BIT_PRE_LSB + i]) begin
                    next_state.ctrl.timeout_select_field[i] =
                        data[`WDT_BIT_PRE_LSB + i];
                end
            end
            if (mask[`WDT_BIT_IRQ_SEL]) begin
                next_state.ctrl.irq_response_select =
                    data[`WDT_BIT_IRQ_SEL];
            end
            if (mask[`WDT_BIT_STATUS] && !data[`WDT_BIT_STATUS]) begin
                next_state.ctrl.timeout_status_flag = 1'b0;
            end
            if (mask[`WDT_BIT_ENABLE]) begin
                next_state.ctrl.watchdog_enable_bit =
                    data[`WDT_BIT_ENABLE];
                restart = data[`WDT_BIT_ENABLE];
            end
        end
        // Reserved codes above the immediate one never expire.
        timed_code = state.ctrl.timeout_select_field
            <= `WDT_PRE_LAST_TIMED;
        expire = 1'b0;
        if (!state.ctrl.watchdog_enable_bit) begin
            next_state.count = '0;
        end else if (restart) begin
            next_state.count = '0;
        end else if (state.ctrl.timeout_select_field
            == `WDT_PRE_IMMEDIATE) begin
            expire = 1'b1;
        end else if (timed_code && rc_tick) begin
            if (state.count
                == wdt_terminal(state.ctrl.timeout_select_field)) begin
                expire = 1'b1;
                next_state.count = '0;
            end else begin
                next_state.count = state.count + 16'h0001;
            end
        end
        if (supply_monitor_irq) begin
            next_state.ctrl.watchdog_enable_bit = 1'b0;
        end
        if (irq_ack) begin
            next_state.irq_req = 1'b0;
        end
        next_state.sys_reset = 1'b0;
        if (expire) begin
            // The timeout wins over a same-cycle software clear.
            next_state.ctrl.timeout_status_flag = 1'b1;
            if (state.ctrl.irq_response_select
                && state.ctrl.timeout_select_field
                != `WDT_PRE_IMMEDIATE) begin
                next_state.irq_req = 1'b1;
            end else begin
                next_state.sys_reset = 1'b1;
                next_state.ctrl = wdt_reset_ctrl(1'b1);
                next_state.count = '0;
                next_state.irq_req = 1'b0;
            end
        end
        next_state.rdata = 8'h00;
        if (sfr_req.addr == `WDT_CTRL_ADDR) begin
            next_state.rdata = wdt_pack(state.ctrl);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= '{ctrl: `WDT_CTRL_RESET, count: '0, rc_sync: 3'h0,
                rdata: 8'h00, irq_req: 1'b0, sys_reset: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // No global enable gates this request; the core must take it.
    assign wd_irq_req = state.irq_req;
    assign wd_system_reset = state.sys_reset;
    assign sfr_rdata = state.rdata;
    assign timeout_status_flag = state.ctrl.timeout_status_flag;

endmodule

// File: bench/wdt_unit_asserts.sv
// Checker of the watchdog unit's port behaviour.
`timescale 1ns/1ns
module wdt_unit_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register access
    input wire wdt_pkg::wdt_sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Requests
    input wire logic irq_ack,
    input wire logic supply_monitor_irq,
    input wire logic wd_irq_req,
    input wire logic wd_system_reset,
    input wire logic timeout_status_flag
);
    wire wr = sfr_req.byte_wr | sfr_req.bit_wr;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    property p_rs_st; wd_system_reset |-> timeout_status_flag; endproperty
    a_rs_st: assert property (p_rs_st) else $error("reset no status");
    property p_rs_one; wd_system_reset |=> !wd_system_reset; endproperty
    a_rs_one: assert property (p_rs_one) else $error("long reset");
    property p_irq_st; $rose(wd_irq_req) |-> timeout_status_flag; endproperty
    a_irq_st: assert property (p_irq_st) else $error("irq no status");
    property p_hold; wd_irq_req && !irq_ack |=> wd_irq_req; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_st_up;
        $rose(timeout_status_flag) |-> wd_system_reset || wd_irq_req;
    endproperty
    a_st_up: assert property (p_st_up) else $error("status set");
    property p_st_dn; $fell(timeout_status_flag) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_st_dn: assert property (p_st_dn) else $error("status lost");
    property p_rd; sfr_req.addr != 8'hC0 |=> sfr_rdata == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("bad read data");
    property p_psm;
        supply_monitor_irq ##1 supply_monitor_irq |=> !wd_system_reset;
    endproperty
    a_psm: assert property (p_psm) else $error("reset in alarm");
endmodule
bind wdt_unit wdt_unit_chk u_chk (.core_clk(core_clk), .reset(reset),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack),
    .supply_monitor_irq(supply_monitor_irq), .wd_irq_req(wd_irq_req),
    .wd_system_reset(wd_system_reset),
    .timeout_status_flag(timeout_status_flag));

// File: bench/wdt_core_model.sv
// Processor core model reaching the watchdog through its register.
`timescale 1ns/1ns
module wdt_core_model (
    // Clock
    input wire logic core_clk,
    // Register access
    output wdt_pkg::wdt_sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata
);
    initial sfr_req = '0;
    task automatic put(input logic bw, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_req = '{byte_wr: bw, bit_wr: !bw, addr: a, wdata: d, bit_val: d[0]};
        @(posedge core_clk);
        #1;
        sfr_req.byte_wr = 1'b0;
        sfr_req.bit_wr = 1'b0;
    endtask
    // The unlock goes right before the write; nothing else writes between.
    task automatic wr_ctl(input logic [7:0] d);
        put(1'b0, 8'hC0, 8'h01);
        put(1'b1, 8'hC0, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_req.addr = a;
        @(posedge core_clk);
        #1;
        d = sfr_rdata;
    endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the watchdog timer unit.
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic rc_osc_clk = 1'b0;
    logic irq_ack = 1'b0;
    logic supply_monitor_irq = 1'b0;
    wdt_pkg::wdt_sfr_req_type sfr_req;
    logic [7:0] sfr_rdata;
    logic wd_irq_req;
    logic wd_system_reset;
    logic timeout_status_flag;
    logic [7:0] rv;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #2 core_clk = ~core_clk;
    // A fast oscillator keeps the 512-tick intervals inside the run time.
    always #32 rc_osc_clk = ~rc_osc_clk;
    wdt_core_model u_core (.core_clk(core_clk), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata));
    wdt_unit u_dut (.core_clk(core_clk), .reset(reset),
        .rc_osc_clk(rc_osc_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .irq_ack(irq_ack), .supply_monitor_irq(supply_monitor_irq),
        .wd_irq_req(wd_irq_req), .wd_system_reset(wd_system_reset),
        .timeout_status_flag(timeout_status_flag));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_out(input int n);
        for (int i = 0; i < n && wd_irq_req !== 1'b1
            && wd_system_reset !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        #1 reset = 1'b0;
        u_core.rd(8'hC0, rv);
        check(rv, 8'h10);
        u_core.put(1'b1, 8'hC0, 8'h0A);
        u_core.rd(8'hC0, rv);
        check(rv, 8'h10);
        u_core.put(1'b0, 8'hC0, 8'h01);
        u_core.put(1'b1, 8'hC8, 8'h00);
        u_core.put(1'b1, 8'hC0, 8'h0A);
        u_core.rd(8'hC0, rv);
        check(rv, 8'h10);
        u_core.wr_ctl(8'h0A);
        u_core.rd(8'hC0, rv);
        check(rv, 8'h0A);
        repeat (7800) @(posedge core_clk);
        check({7'h00, wd_irq_req}, 8'h00);
        wait_out(800);
        check({wd_system_reset, wd_irq_req, timeout_status_flag}, 3'h3);
        u_core.put(1'b0, 8'hC1, 8'h01);
        #4 irq_ack = 1'b1;
        #4 irq_ack = 1'b0;
        check({7'h00, wd_irq_req}, 8'h00);
        u_core.wr_ctl(8'h02);
        check({7'h00, timeout_status_flag}, 8'h00);
        wait_out(9000);
        check({wd_system_reset, timeout_status_flag}, 2'h3);
        u_core.rd(8'hC0, rv);
        check(rv, 8'h14);
        u_core.wr_ctl(8'h86);
        wait_out(20);
        check({wd_system_reset, timeout_status_flag}, 2'h3);
        supply_monitor_irq = 1'b1;
        u_core.wr_ctl(8'h0A);
        repeat (9000) @(posedge core_clk);
        u_core.rd(8'hC0, rv);
        check(rv, 8'h08);
        end_sim();
    end
endmodule
